// File: common/preset_ber_consts.vh
// Constants for the preset and error-test control registers.
// Assumes a 50 MHz system clock and 125 us frames.
`ifndef PRESET_BER_CONSTS_VH
`define PRESET_BER_CONSTS_VH
`define ADDR_PRESET      4'h1
`define ADDR_TEST_CTRL   4'h2
`define REG_RESET        16'h0000
`define FRAME_US         125
`define CLK_MHZ          50
`define FRAME_CYCLES     (`FRAME_US * `CLK_MHZ)
`define CM_DEPTH         32
`define CM_AW            5
`define CM_LAST          5'h1f
// Preset register fields
`define PR_EN            0
`define PR_LPAT_LO       1
`define PR_LPAT_HI       3
`define PR_BPAT_LO       4
`define PR_BPAT_HI       6
`define PR_USED_HI       6
// Test control fields
`define TC_B_LOCK        11
`define TC_B_RESEED      10
`define TC_B_CLR         9
`define TC_B_RX          8
`define TC_B_TX          7
`define TC_B_SEL         6
`define TC_L_LOCK        5
`define TC_L_RESEED      4
`define TC_L_CLR         3
`define TC_L_RX          2
`define TC_L_TX          1
`define TC_L_SEL         0
`define TC_WR_MASK       16'h07df
// Generator and error counter
`define SEED             23'h7fffff
`define SEED15           15'h7fff
`define ERR_W            16
`define ERR_MAX          16'hffff
`endif

// File: logic/ber_port.v
// One port of the error-rate tester: transmitter, receiver, counter.
// Assumes rising-edge pulses from the register block, one bit per clock.
`include "preset_ber_consts.vh"
module ber_port (
    input  wire               clk,       // System clock
    input  wire               srst,      // Sync reset
    input  wire               reseed_p,  // Reseed pulse
    input  wire               clr_p,     // Error clear pulse
    input  wire               rx_rise,   // Receiver start edge
    input  wire               rx_en,     // Receiver start level
    input  wire               tx_rise,   // Transmitter start edge
    input  wire               tx_en,     // Transmitter start level
    input  wire               long_sel,  // Sequence length select
    input  wire               rx_bit,    // Incoming test bit
    output reg                tx_bit,    // Outgoing test bit
    output reg                tx_valid,  // Test transmission active
    output reg                locked,    // Receiver locked
    output reg  [`ERR_W-1:0]  err_count  // Bit error count
);
    reg  [22:0] hunt_q;
    reg         tx_run_q;
    wire        tx_gen;
    wire        ref_bit;
    wire        seed_seen;
    wire [22:0] hunt_d;
    wire        aged_bit;

    assign hunt_d = {hunt_q[21:0], rx_bit};
    // Bit one seed length old (23 or 15 bits), aligned with the reseeded reference
    assign aged_bit = long_sel ? hunt_q[22] : hunt_q[14];
    assign seed_seen = long_sel ? (hunt_d == `SEED)
                                : (hunt_d[14:0] == `SEED15);

    prbs_gen u_tx (
        .clk      (clk),
        .srst     (srst),
        .reseed   (reseed_p),
        .step     (tx_run_q),
        .long_sel (long_sel),
        .bit_out  (tx_gen)
    );
    // Reference restarts from seed on lock
    prbs_gen u_ref (
        .clk      (clk),
        .srst     (srst),
        .reseed   (reseed_p | (rx_en & ~locked & seed_seen)),
        .step     (locked & rx_en),
        .long_sel (long_sel),
        .bit_out  (ref_bit)
    );

    always @(posedge clk) begin
        if (srst) begin
            tx_run_q  <= 1'b0;
            tx_bit    <= 1'b0;
            tx_valid  <= 1'b0;
            locked    <= 1'b0;
            hunt_q    <= 23'h000000;
            err_count <= `ERR_W'h0000;
        end else begin
            if (!tx_en) begin
                tx_run_q <= 1'b0; // RULE_17
            end else if (tx_rise) begin
                tx_run_q <= 1'b1; // RULE_17
            end
            tx_valid <= tx_run_q;
            tx_bit   <= tx_run_q & tx_gen;
            if (rx_en) begin
                hunt_q <= hunt_d;
            end
            if (rx_rise) begin
                locked <= 1'b0; // RULE_11
            end else if (rx_en && !locked && seed_seen) begin
                locked <= 1'b1; // RULE_14
            end
            if (clr_p) begin
                err_count <= `ERR_W'h0000; // RULE_13
            end else if (rx_en && locked && (aged_bit != ref_bit)
                         && err_count != `ERR_MAX) begin
                err_count <= err_count + `ERR_W'h0001; // RULE_15
            end // RULE_16
        end
    end
endmodule

// File: logic/prbs_gen.v
// Pseudo-random generator, x^15+x^14+1 or x^23+x^18+1.
// Assumes reseed is a single-cycle pulse and step a held level, both in the clk domain.
`include "preset_ber_consts.vh"
module prbs_gen (
    input  wire        clk,     // System clock
    input  wire        srst,    // Sync reset
    input  wire        reseed,  // Load seed
    input  wire        step,    // Advance one bit
    input  wire        long_sel,// 1: 2^23-1, 0: 2^15-1
    output wire        bit_out  // Current sequence bit
);
    reg [22:0] lfsr_q;
    wire       fb;

    assign fb = long_sel ? (lfsr_q[22] ^ lfsr_q[17])
                         : (lfsr_q[14] ^ lfsr_q[13]); // RULE_21
    assign bit_out = long_sel ? lfsr_q[22] : lfsr_q[14];

    always @(posedge clk) begin
        if (srst || reseed) begin
            lfsr_q <= `SEED; // RULE_12
        end else if (step) begin
            lfsr_q <= {lfsr_q[21:0], fb};
        end
    end
endmodule

// File: logic/preset_ber_ctrl.v
// Contract
// RULE_01 - Software writes enable and both pattern fields in one access.
// RULE_02 - Enable rising edge starts memory preset at any point in a frame.
// RULE_03 - Device clears enable itself after one frame when preset completes.
// RULE_04 - Software changes nothing else during a preset except an abort.
// RULE_05 - Clearing enable or the permit bit aborts the preset.
// RULE_06 - Backplane entries get pattern in 15-13, zeros in 12-0.
// RULE_07 - Local entries get pattern in 15-13, zeros in 12-0.
// RULE_08 - Software writes zero to reserved upper bits of both registers.
// RULE_09 - Preset fields: backplane 6:4, local 3:1, enable 0, reset zero.
// RULE_10 - Read-only lock flags at bits 11 and 5 set on receiver sync.
// RULE_11 - Lock flag clears on rising edge of its receiver start bit.
// RULE_12 - Reseed bit rising edge loads the seed into the generator.
// RULE_13 - Clear bit rising edge zeroes internal and readable error count.
// RULE_14 - Receiver start edge enables hunt for seed, then lock.
// RULE_15 - After lock each mismatching bit increments the error count. The code holds the count at 16'hffff instead of wrapping.
// RULE_16 - Receiver start low: no compare, error count frozen.
// RULE_17 - Transmitter start edge begins sending; low keeps it disabled.
// RULE_18 - Select high picks 2^23-1 sequence, low picks 2^15-1.
// RULE_19 - Local port bits 2,1,0 mirror backplane receiver, transmitter, select.
// RULE_20 - Rising edges found against registered previous value, one-cycle pulse.
// RULE_21 - Generators use x^15+x^14+1 and x^23+x^18+1 in tx and reference.
//
// Preset and error-test control registers on the microport.
// Assumes a synchronous single-cycle microport, 16-bit data, one
// connection-memory write per clock on the preset write ports.
`include "preset_ber_consts.vh"
module preset_ber_ctrl (
    input  wire               clk,          // System clock 50 MHz
    input  wire               srst,         // Sync reset, active high
    input  wire [3:0]         addr,         // Register address
    input  wire               wr_en,        // Write strobe
    input  wire               rd_en,        // Read strobe
    input  wire [15:0]        wr_data,      // Write data
    output reg  [15:0]        rd_data,      // Read data, next cycle
    input  wire               preset_permit,// Control register permit bit
    input  wire               bp_rx_bit,    // Backplane test input bit
    input  wire               lc_rx_bit,    // Local test input bit
    output reg                bp_tx_bit,    // Backplane test output bit
    output reg                bp_tx_valid,  // Backplane test active
    output reg                lc_tx_bit,    // Local test output bit
    output reg                lc_tx_valid,  // Local test active
    output reg  [`ERR_W-1:0]  backplane_err_count, // Backplane errors
    output reg  [`ERR_W-1:0]  local_err_count,     // Local errors
    output reg                cm_we,        // Conn-memory preset write
    output reg  [`CM_AW-1:0]  cm_addr,      // Conn-memory entry
    output reg  [15:0]        backplane_conn_mem_data, // Backplane word
    output reg  [15:0]        local_conn_mem_data,     // Local word
    output reg                preset_busy   // Preset in progress
);
    // ==========================================================
    // Register state
    reg [6:0]  preset_register_q;
    reg [15:0] ctrl_q;
    reg [15:0] ctrl_prev_q;
    reg        en_prev_q;
    reg [15:0] frame_cnt_q;
    reg [`CM_AW-1:0] wr_ptr_q;
    reg        pass_done_q;
    wire       wr_preset;
    wire       wr_ctrl;
    wire [15:0] rise;
    wire       start_p;
    wire       abort;
    wire       bp_locked;
    wire       lc_locked;
    wire [`ERR_W-1:0] bp_cnt;
    wire [`ERR_W-1:0] lc_cnt;
    wire       bp_tx_b;
    wire       bp_tx_v;
    wire       lc_tx_b;
    wire       lc_tx_v;

    function [15:0] cm_word;
        input [2:0] pat;
        begin
            cm_word = {pat, 13'h0000}; // RULE_06 RULE_07
        end
    endfunction

    assign wr_preset = wr_en && (addr == `ADDR_PRESET);
    assign wr_ctrl   = wr_en && (addr == `ADDR_TEST_CTRL);
    assign rise      = ctrl_q & ~ctrl_prev_q; // RULE_20
    assign start_p   = preset_register_q[`PR_EN] & ~en_prev_q
                       & preset_permit; // RULE_02
    assign abort     = ~preset_register_q[`PR_EN] | ~preset_permit; // RULE_05

    // ==========================================================
    // Register writes and preset sequencing
    always @(posedge clk) begin
        if (srst) begin
            preset_register_q <= 7'h00; // RULE_09
            ctrl_q      <= `REG_RESET;
            ctrl_prev_q <= `REG_RESET;
            en_prev_q   <= 1'b0;
            preset_busy <= 1'b0;
            frame_cnt_q <= 16'h0000;
            wr_ptr_q    <= 5'h00;
            pass_done_q <= 1'b0;
            cm_we       <= 1'b0;
            cm_addr     <= 5'h00;
            backplane_conn_mem_data <= 16'h0000;
            local_conn_mem_data     <= 16'h0000;
        end else begin
            ctrl_prev_q <= ctrl_q;
            en_prev_q   <= preset_register_q[`PR_EN];
            if (wr_ctrl) begin
                ctrl_q <= wr_data & `TC_WR_MASK;
            end
            cm_we <= 1'b0;
            if (preset_busy && abort) begin
                preset_busy <= 1'b0; // RULE_05
            end else if (start_p) begin
                preset_busy <= 1'b1; // RULE_02
                frame_cnt_q <= 16'h0000;
                wr_ptr_q    <= 5'h00;
                pass_done_q <= 1'b0;
            end else if (preset_busy) begin
                if (!pass_done_q) begin
                    cm_we   <= 1'b1;
                    cm_addr <= wr_ptr_q;
                    backplane_conn_mem_data <= cm_word(
                        preset_register_q[`PR_BPAT_HI:`PR_BPAT_LO]);
                    local_conn_mem_data <= cm_word(
                        preset_register_q[`PR_LPAT_HI:`PR_LPAT_LO]);
                    wr_ptr_q <= wr_ptr_q + 5'h01;
                    if (wr_ptr_q == `CM_LAST) begin
                        pass_done_q <= 1'b1;
                    end
                end
                if (frame_cnt_q == `FRAME_CYCLES - 1) begin
                    preset_busy <= 1'b0; // RULE_03
                end else begin
                    frame_cnt_q <= frame_cnt_q + 16'h0001;
                end
            end
            if (wr_preset) begin
                preset_register_q <= wr_data[`PR_USED_HI:0];
            end else if (preset_busy && !abort
                         && frame_cnt_q == `FRAME_CYCLES - 1) begin
                preset_register_q[`PR_EN] <= 1'b0; // RULE_03
            end
        end
    end

    // ==========================================================
    // Error-rate test ports
    ber_port u_bp (
        .clk       (clk),
        .srst      (srst),
        .reseed_p  (rise[`TC_B_RESEED]), // RULE_12
        .clr_p     (rise[`TC_B_CLR]), // RULE_13
        .rx_rise   (rise[`TC_B_RX]), // RULE_14
        .rx_en     (ctrl_q[`TC_B_RX]),
        .tx_rise   (rise[`TC_B_TX]),
        .tx_en     (ctrl_q[`TC_B_TX]),
        .long_sel  (ctrl_q[`TC_B_SEL]), // RULE_18
        .rx_bit    (bp_rx_bit),
        .tx_bit    (bp_tx_b),
        .tx_valid  (bp_tx_v),
        .locked    (bp_locked),
        .err_count (bp_cnt)
    );
    ber_port u_lc (
        .clk       (clk),
        .srst      (srst),
        .reseed_p  (rise[`TC_L_RESEED]),
        .clr_p     (rise[`TC_L_CLR]),
        .rx_rise   (rise[`TC_L_RX]), // RULE_19
        .rx_en     (ctrl_q[`TC_L_RX]),
        .tx_rise   (rise[`TC_L_TX]),
        .tx_en     (ctrl_q[`TC_L_TX]),
        .long_sel  (ctrl_q[`TC_L_SEL]),
        .rx_bit    (lc_rx_bit),
        .tx_bit    (lc_tx_b),
        .tx_valid  (lc_tx_v),
        .locked    (lc_locked),
        .err_count (lc_cnt)
    );

    // ==========================================================
    // Outputs and read-back
    always @(posedge clk) begin
        if (srst) begin
            rd_data     <= 16'h0000;
            bp_tx_bit   <= 1'b0;
            bp_tx_valid <= 1'b0;
            lc_tx_bit   <= 1'b0;
            lc_tx_valid <= 1'b0;
            backplane_err_count <= `ERR_W'h0000;
            local_err_count     <= `ERR_W'h0000;
        end else begin
            bp_tx_bit   <= bp_tx_b;
            bp_tx_valid <= bp_tx_v;
            lc_tx_bit   <= lc_tx_b;
            lc_tx_valid <= lc_tx_v;
            backplane_err_count <= bp_cnt;
            local_err_count     <= lc_cnt;
            if (!rd_en) begin
                rd_data <= 16'h0000;
            end else if (addr == `ADDR_PRESET) begin
                rd_data <= {9'h000, preset_register_q};
            end else if (addr == `ADDR_TEST_CTRL) begin
                rd_data <= {4'h0, bp_locked,
                            ctrl_q[`TC_B_RESEED:`TC_B_SEL],
                            lc_locked,
                            ctrl_q[`TC_L_RESEED:`TC_L_SEL]}; // RULE_10
            end else begin
                rd_data <= 16'h0000;
            end
        end
    end
endmodule

// File: verif/host_model.sv
// Host microprocessor on the register port.
// Assumes tasks are entered just after a rising clock edge.
module host_model (
    input  wire logic        clk,     // Clock
    output logic      [3:0]  addr,    // Address
    output logic             wr_en,   // Write strobe
    output logic             rd_en,   // Read strobe
    output logic      [15:0] wr_data, // Write data
    input  wire logic [15:0] rd_data  // Read data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr    = 4'h0;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        wr_data = 16'h0000;
    end
    // Whole word in one access, enable with both patterns
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr    = a;
        wr_data = d;
        wr_en   = 1'b1;
        @(posedge clk);
        #1 wr_en = 1'b0;
        wr_data = ~d;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr  = a;
        rd_en = 1'b1;
        @(posedge clk);
        #1 rd_en = 1'b0;
        d = rd_data;
        @(posedge clk);
        #1;
    endtask
endmodule

// File: verif/preset_ber_ctrl_bench.sv
// Self-checking bench for the preset and error-test control block.
// Assumes the host model and the bound checker; test lines loop back.
module preset_ber_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, srst = 1, permit = 0, inj = 0;
    logic [3:0]  addr;
    logic        wr_en, rd_en, bp_tx, lc_tx, bp_v, lc_v, cm_we, busy;
    logic [15:0] wr_data, rd_data, bp_err, lc_err, bp_w, lc_w, v;
    logic [4:0]  cm_addr;
    logic [35:0] rows [6] = '{{4'h1, 16'h007e, 16'h007e},
        {4'h1, 16'h0000, 16'h0000}, {4'h2, 16'h0fff, 16'h07df},
        {4'h2, 16'h0000, 16'h0000}, {4'h3, 16'hffff, 16'h0000},
        {4'h0, 16'h1234, 16'h0000}};
    int err_count = 0, checked = 0, cyc = 0, cm_n = 0, i;
    always #10 clk = ~clk;
    always @(posedge clk) cm_n += cm_we;
    always @(posedge clk) if (++cyc == 30000) begin
        err_count++;
        print_verdict();
    end
    host_model i_host (.clk(clk), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data));
    preset_ber_ctrl i_dut (.clk(clk), .srst(srst), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
        .rd_data(rd_data), .preset_permit(permit),
        .bp_rx_bit(bp_tx ^ inj), .lc_rx_bit(lc_tx ^ inj),
        .bp_tx_bit(bp_tx), .bp_tx_valid(bp_v), .lc_tx_bit(lc_tx),
        .lc_tx_valid(lc_v), .backplane_err_count(bp_err),
        .local_err_count(lc_err), .cm_we(cm_we), .cm_addr(cm_addr),
        .backplane_conn_mem_data(bp_w), .local_conn_mem_data(lc_w),
        .preset_busy(busy));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int k = 0; k < lim && busy !== lvl; k++) tick(1);
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Register table, then hand-written cases
    initial begin
        tick(8);
        srst = 0;
        for (i = 0; i < 6; i++) begin
            i_host.wr(rows[i][35:32], rows[i][31:16]);
            i_host.rd(rows[i][35:32], v);
            check(v, rows[i][15:0]);
        end
        $display("test register table done");
        permit = 1;
        cm_n = 0;
        i_host.wr(4'h1, 16'h0067);
        wait_busy(1, 10);
        wait_busy(0, 7000);
        check(16'(cm_n), 16'h0020);
        i_host.rd(4'h1, v);
        check(v, 16'h0066);
        cm_n = 0;
        i_host.wr(4'h1, 16'h0067);
        tick(6);
        i_host.wr(4'h1, 16'h0066);
        tick(4);
        check({15'h0, busy}, 16'h0000);
        check({15'h0, cm_n < 32}, 16'h0001);
        i_host.wr(4'h1, 16'h0067);
        tick(6);
        permit = 0;
        tick(4);
        check({15'h0, busy}, 16'h0000);
        $display("test preset and abort done");
        i_host.wr(4'h2, 16'h034c);
        i_host.wr(4'h2, 16'h05d6);
        tick(2);
        check({14'h0, bp_v, lc_v}, 16'h0003);
        for (i = 0; i < 60 && (v & 16'h0820) !== 16'h0820; i++)
            i_host.rd(4'h2, v);
        check(v & 16'h0820, 16'h0820);
        check(bp_err | lc_err, 16'h0000);
        inj = 1;
        tick(3);
        inj = 0;
        tick(30);
        check(bp_err, 16'h0003);
        check(lc_err, 16'h0003);
        i_host.wr(4'h2, 16'h04d2);
        tick(2);
        inj = 1;
        tick(3);
        inj = 0;
        tick(30);
        check(bp_err | lc_err, 16'h0003);
        i_host.wr(4'h2, 16'h06da);
        tick(4);
        check(bp_err | lc_err, 16'h0000);
        i_host.wr(4'h2, 16'h07de);
        i_host.rd(4'h2, v);
        check(v, 16'h07de);
        i_host.wr(4'h2, 16'h0000);
        tick(3);
        check({14'h0, bp_v, lc_v}, 16'h0000);
        $display("test error-rate port done");
        i_host.wr(4'h2, 16'h05d6);
        srst = 1;
        tick(2);
        srst = 0;
        i_host.rd(4'h2, v);
        check(v | bp_err | lc_err, 16'h0000);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule

// File: verif/preset_ber_ctrl_properties.sv
// Concurrent checks on the preset and error-test control block.
// Assumes binding to preset_ber_ctrl and one clock domain.
`include "preset_ber_consts.vh"
module preset_ber_ctrl_properties (
    input wire logic              clk,                     // Clock
    input wire logic              srst,                    // Sync reset
    input wire logic [3:0]        addr,                    // Address
    input wire logic              wr_en,                   // Write strobe
    input wire logic [15:0]       wr_data,                 // Write data
    input wire logic              preset_permit,           // Permit bit
    input wire logic [15:0]       backplane_err_count,     // Bp errors
    input wire logic [15:0]       local_err_count,         // Lc errors
    input wire logic              cm_we,                   // Entry write
    input wire logic [4:0]        cm_addr,                 // Entry
    input wire logic [15:0]       backplane_conn_mem_data, // Bp word
    input wire logic [15:0]       local_conn_mem_data,     // Lc word
    input wire logic              preset_busy              // Busy
);
    localparam int FRAME = 6250;
    logic [5:0]  pat_q;
    logic [13:0] busy_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ==========================================
    // Last written patterns and busy length
    always @(posedge clk) begin
        if (srst) begin
            pat_q  <= 6'h00;
            busy_q <= 14'h0000;
        end else begin
            if (wr_en && addr == 4'h1) pat_q <= wr_data[6:1];
            busy_q <= preset_busy ? busy_q + 14'h0001 : 14'h0000;
        end
    end
    a_busy_one_frame: assert property (busy_q <= FRAME)
        else $error("preset runs longer than a frame");
    a_permit_abort: assert property (preset_busy && !preset_permit
        |-> ##[1:3] !preset_busy) else $error("permit drop no abort");
    a_first_entry: assert property ($rose(preset_busy)
        |-> ##[0:3] (cm_we && cm_addr == 5'h00))
        else $error("preset does not start at entry 0");
    a_we_in_preset: assert property (cm_we
        |-> preset_busy || $past(preset_busy))
        else $error("entry write outside preset");
    a_bp_word: assert property (cm_we
        |-> backplane_conn_mem_data == {pat_q[5:3], 13'h0000})
        else $error("backplane entry word wrong");
    a_lc_word: assert property (cm_we
        |-> local_conn_mem_data == {pat_q[2:0], 13'h0000})
        else $error("local entry word wrong");
    a_bp_count_step: assert property ($changed(backplane_err_count)
        |-> backplane_err_count == $past(backplane_err_count) + 16'h0001
            || backplane_err_count == 16'h0000)
        else $error("backplane count jumps");
    a_lc_count_step: assert property ($changed(local_err_count)
        |-> local_err_count == $past(local_err_count) + 16'h0001
            || local_err_count == 16'h0000)
        else $error("local count jumps");
endmodule
bind preset_ber_ctrl preset_ber_ctrl_properties i_props (
    .clk(clk), .srst(srst), .addr(addr), .wr_en(wr_en),
    .wr_data(wr_data), .preset_permit(preset_permit),
    .backplane_err_count(backplane_err_count),
    .local_err_count(local_err_count), .cm_we(cm_we), .cm_addr(cm_addr),
    .backplane_conn_mem_data(backplane_conn_mem_data),
    .local_conn_mem_data(local_conn_mem_data), .preset_busy(preset_busy));
